// *** hw/nvc_pkg.sv ***
// package: register map, field layout, reset values, timing for the data eeprom controller
package nvc_pkg;
    localparam logic [7:0] ADDR_DATA    = 8'h9a;
    localparam logic [7:0] ADDR_ADDRESS = 8'h9b;
    localparam logic [7:0] ADDR_CTRL    = 8'h9c;
    localparam logic [7:0] ADDR_UNLOCK  = 8'h9d;
    localparam int BIT_RD    = 0;
    localparam int BIT_WR    = 1;
    localparam int BIT_WRITE_PERMIT  = 2;
    localparam int BIT_WRITE_ABORT_FLAG = 3;
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam int NV_DEPTH = 128;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] ERASED     = 8'hFF;
    // core cycles allowed between consecutive sequence steps (one instruction pair)
    localparam logic [3:0] SEQ_GAP    = 4'h2;
    localparam int CLK_MHZ            = 100;
    localparam int WRITE_TIME_US      = 4;
    localparam int WRITE_CYCLES       = WRITE_TIME_US * CLK_MHZ;
    localparam int ERASE_CYCLES       = WRITE_CYCLES / 2;
    localparam int PWRT_TIME_MS       = 72;
    localparam int PWRT_CYCLES        = PWRT_TIME_MS * 1000 * CLK_MHZ;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } nvc_bus_t;
    typedef enum logic [1:0] {
        NVC_IDLE  = 2'b00,
        NVC_ERASE = 2'b01,
        NVC_PROG  = 2'b11
    } nvc_state_t;
endpackage

// *** hw/nvc_timer.sv ***
// down counter giving a one-cycle done pulse after a loaded count
`timescale 1ns/10ps
`default_nettype none
module nvc_timer #(
    parameter int W = 24
) (
    input  wire logic         i_mclk,
    input  wire logic         i_rst,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_count,
    output logic              o_busy,
    output logic              o_done
);
    logic [W-1:0] cnt;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cnt    <= '0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_load) begin
                cnt    <= i_count;
                o_busy <= 1'b1;
            end else if (o_busy) begin
                if (cnt <= W'(1)) begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                end
                cnt <= cnt - W'(1);
            end
        end
    end
endmodule
`default_nettype wire

// *** hw/nvc_ctrl.sv ***
// data eeprom access controller: special registers, unlock, self-timed write, array
`timescale 1ns/10ps
`default_nettype none
module nvc_ctrl #(
    parameter int PWRT_CYCLES = nvc_pkg::PWRT_CYCLES
) (
    input  wire logic             i_mclk,
    input  wire logic             i_rst,
    input  wire logic             i_por,
    input  wire logic             i_abort_rst,
    input  wire nvc_pkg::nvc_bus_t i_bus,
    input  wire logic             i_code_protect,
    input  wire logic             i_prog_rd,
    input  wire logic [6:0]       i_prog_addr,
    input  wire logic             i_done_clr,
    output logic [7:0]            o_rdata,
    output logic                  o_write_done_flag,
    output logic                  o_busy,
    output logic [7:0]            o_prog_rdata,
    output logic                  o_prog_denied
);
    localparam int TW = 24;
    localparam int PW = $clog2(PWRT_CYCLES + 1);

    logic [7:0]         mem [nvc_pkg::NV_DEPTH];
    logic [6:0]         nv_byte_address;
    logic [7:0]         nv_byte_data;
    logic               write_permit;
    logic               write_abort_flag;
    logic               rd_strobe;
    logic               wr_strobe;
    logic [1:0]         key_step;
    logic [3:0]         gap_cnt;
    logic [PW-1:0]      pwrt_cnt;
    logic               pwrt_run;
    nvc_pkg::nvc_state_t state;
    nvc_pkg::nvc_state_t next_state;
    logic               tmr_load;
    logic [TW-1:0]      tmr_count;
    logic               tmr_done;
    logic               wr_ctrl;
    logic               wr_unlock;
    logic               start_write;
    logic               write_end;

    assign wr_ctrl   = i_bus.wr && i_bus.addr == nvc_pkg::ADDR_CTRL;
    assign wr_unlock = i_bus.wr && i_bus.addr == nvc_pkg::ADDR_UNLOCK;
    assign pwrt_run  = pwrt_cnt != '0;

    assign start_write = wr_ctrl && i_bus.wdata[nvc_pkg::BIT_WR] && !wr_strobe
                         && write_permit && key_step == 2'd2 && !pwrt_run
                         && gap_cnt == nvc_pkg::SEQ_GAP
                         && state == nvc_pkg::NVC_IDLE;
    assign write_end = state == nvc_pkg::NVC_PROG && tmr_done;

    // power-up timer, restarted by power-on and by reset
    // any reset reloads it as well, so writes wait after each reset
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pwrt_cnt <= PW'(PWRT_CYCLES);
        end else if (i_por) begin
            pwrt_cnt <= PW'(PWRT_CYCLES);
        end else if (pwrt_run) begin
            pwrt_cnt <= pwrt_cnt - PW'(1);
        end
    end

    // sequence cycle count
    // every step must land exactly SEQ_GAP cycles after the previous one
    // an early or late step drops the sequence back to idle
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            key_step <= 2'd0;
            gap_cnt  <= 4'h0;
        end else if (wr_unlock) begin
            gap_cnt <= 4'h1;
            if (i_bus.wdata == nvc_pkg::KEY_FIRST) begin
                key_step <= 2'd1;
            end else if (i_bus.wdata == nvc_pkg::KEY_SECOND && key_step == 2'd1
                         && gap_cnt == nvc_pkg::SEQ_GAP) begin
                key_step <= 2'd2;
            end else begin
                key_step <= 2'd0;
            end
        end else if (key_step != 2'd0) begin
            gap_cnt <= gap_cnt + 4'h1;
            if (wr_ctrl || gap_cnt >= nvc_pkg::SEQ_GAP) begin
                key_step <= (wr_ctrl && gap_cnt == nvc_pkg::SEQ_GAP && key_step == 2'd2) ? 2'd2 : 2'd0;
            end
            if (wr_ctrl || gap_cnt > nvc_pkg::SEQ_GAP) begin
                key_step <= 2'd0;
            end
        end
    end

    always_comb begin
        next_state = state;
        tmr_load   = 1'b0;
        tmr_count  = TW'(nvc_pkg::ERASE_CYCLES);
        case (state)
            nvc_pkg::NVC_IDLE: begin
                if (start_write) begin
                    next_state = nvc_pkg::NVC_ERASE;
                    tmr_load   = 1'b1;
                end
            end
            nvc_pkg::NVC_ERASE: begin
                if (tmr_done) begin
                    next_state = nvc_pkg::NVC_PROG;
                    tmr_load   = 1'b1;
                    tmr_count  = TW'(nvc_pkg::WRITE_CYCLES - nvc_pkg::ERASE_CYCLES);
                end
            end
            nvc_pkg::NVC_PROG: begin
                if (tmr_done) begin
                    next_state = nvc_pkg::NVC_IDLE;
                end
            end
            default: next_state = nvc_pkg::NVC_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state <= nvc_pkg::NVC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    nvc_timer #(.W(TW)) u_timer (
        .i_mclk  (i_mclk),
        .i_rst   (i_rst),
        .i_load  (tmr_load),
        .i_count (tmr_count),
        .o_busy  (),
        .o_done  (tmr_done)
    );

    always_ff @(posedge i_mclk) begin
        if (state == nvc_pkg::NVC_ERASE && tmr_done) begin
            mem[nv_byte_address] <= nvc_pkg::ERASED;
        end else if (write_end) begin
            mem[nv_byte_address] <= mem[nv_byte_address] & nv_byte_data;
        end
    end

    // address kept for retry
    // cleared only at power-on, so a reset in mid-write leaves it
    always_ff @(posedge i_mclk) begin
        if (i_por) begin
            nv_byte_address <= 7'h00;
        end else if (i_bus.wr && i_bus.addr == nvc_pkg::ADDR_ADDRESS && state == nvc_pkg::NVC_IDLE) begin
            nv_byte_address <= i_bus.wdata[6:0];
        end
    end

    // data held until read or write
    // cleared only at power-on, so a retry finds the old byte
    always_ff @(posedge i_mclk) begin
        if (i_por) begin
            nv_byte_data <= nvc_pkg::BYTE_RESET;
        end else if (rd_strobe) begin
            nv_byte_data <= mem[nv_byte_address];
        end else if (i_bus.wr && i_bus.addr == nvc_pkg::ADDR_DATA && state == nvc_pkg::NVC_IDLE) begin
            nv_byte_data <= i_bus.wdata;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rd_strobe <= 1'b0;
        end else begin
            rd_strobe <= wr_ctrl && i_bus.wdata[nvc_pkg::BIT_RD] && state == nvc_pkg::NVC_IDLE;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wr_strobe <= 1'b0;
        end else if (start_write) begin
            wr_strobe <= 1'b1;
        end else if (write_end) begin
            wr_strobe <= 1'b0;
        end
    end

    // permit cleared at power-up and by reset
    // any reset clears it as well, so it must be set again after release
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            write_permit <= 1'b0;
        end else if (i_por) begin
            write_permit <= 1'b0;
        end else if (wr_ctrl) begin
            write_permit <= i_bus.wdata[nvc_pkg::BIT_WRITE_PERMIT];
        end
    end

    // abort flag on reset mid-write
    // no async reset: the flag must outlive the reset it reports
    always_ff @(posedge i_mclk) begin
        if (i_abort_rst && state != nvc_pkg::NVC_IDLE) begin
            write_abort_flag <= 1'b1;
        end else if (i_por) begin
            write_abort_flag <= 1'b0;
        end else if (write_end) begin
            write_abort_flag <= 1'b0;
        end else if (wr_ctrl) begin
            write_abort_flag <= i_bus.wdata[nvc_pkg::BIT_WRITE_ABORT_FLAG];
        end
    end

    // done flag, set wins over clear
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_write_done_flag <= 1'b0;
        end else if (write_end) begin
            o_write_done_flag <= 1'b1;
        end else if (i_done_clr) begin
            o_write_done_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= nvc_pkg::BYTE_RESET;
        end else begin
            case (i_bus.addr)
                nvc_pkg::ADDR_DATA:    o_rdata <= rd_strobe ? mem[nv_byte_address] : nv_byte_data;
                nvc_pkg::ADDR_ADDRESS: o_rdata <= {1'b0, nv_byte_address};
                nvc_pkg::ADDR_CTRL:    o_rdata <= {4'h0, write_abort_flag, write_permit, wr_strobe, rd_strobe};
                default:               o_rdata <= nvc_pkg::BYTE_RESET;
            endcase
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_busy <= 1'b0;
        end else begin
            // from next_state so busy rises on the start edge
            o_busy <= next_state != nvc_pkg::NVC_IDLE;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_prog_rdata  <= nvc_pkg::BYTE_RESET;
            o_prog_denied <= 1'b0;
        end else begin
            o_prog_denied <= i_prog_rd && i_code_protect;
            if (i_prog_rd) begin
                o_prog_rdata <= i_code_protect ? nvc_pkg::BYTE_RESET : mem[i_prog_addr];
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/nvc_core_model.sv ***
// core model: special register accesses and unlock sequence
`timescale 1ns/10ps
`default_nettype none
module nvc_core_model (
    input  wire logic        i_mclk,
    output nvc_pkg::nvc_bus_t o_bus,
    output logic             o_rv
);
    initial o_bus = '0;
    initial o_rv = 1'b0;
    always @(posedge i_mclk) o_rv <= o_bus.rd;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        o_bus = '{1'b1, 1'b0, a, d};
        @(negedge i_mclk);
        o_bus.wr = 1'b0;
        // released data toggles so stale values never look valid
        o_bus.wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge i_mclk);
        o_bus = '{1'b0, 1'b1, a, o_bus.wdata};
        @(negedge i_mclk);
        o_bus.rd = 1'b0;
    endtask
    task automatic unlock(input int gap, input logic [7:0] c);
        wr(nvc_pkg::ADDR_UNLOCK, nvc_pkg::KEY_FIRST);
        repeat (gap) @(negedge i_mclk);
        wr(nvc_pkg::ADDR_UNLOCK, nvc_pkg::KEY_SECOND);
        wr(nvc_pkg::ADDR_CTRL, c);
    endtask
endmodule
`default_nettype wire

// *** sim/nvc_ctrl_checker.sv ***
// checker: port timing of the eeprom controller
`timescale 1ns/10ps
`default_nettype none
module nvc_ctrl_checker #(
    parameter int PWRT_CYCLES = 20
) (
    input wire logic              i_mclk,
    input wire logic              i_rst,
    input wire nvc_pkg::nvc_bus_t i_bus,
    input wire logic              i_code_protect,
    input wire logic              i_prog_rd,
    input wire logic              i_done_clr,
    input wire logic [7:0]        o_rdata,
    input wire logic              o_write_done_flag,
    input wire logic              o_busy,
    input wire logic [7:0]        o_prog_rdata,
    input wire logic              o_prog_denied
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    logic k1, k2, cset, armed;
    assign k1 = i_bus.wr && i_bus.addr == nvc_pkg::ADDR_UNLOCK && i_bus.wdata == nvc_pkg::KEY_FIRST;
    assign k2 = i_bus.wr && i_bus.addr == nvc_pkg::ADDR_UNLOCK && i_bus.wdata == nvc_pkg::KEY_SECOND;
    assign cset = i_bus.wr && i_bus.addr == nvc_pkg::ADDR_CTRL && i_bus.wdata[nvc_pkg::BIT_WR];
    // armed marks a correctly spaced unlock; permit is not visible here
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            armed <= 1'b0;
        end else begin
            armed <= cset && $past(k2, 2) && $past(k1, 4);
        end
    end
    sequence s_start;
        $rose(o_busy);
    endsequence
    sequence s_hold;
        o_busy [*8];
    endsequence
    AST_START_UNLOCKED: assert property (s_start |-> armed || $past(armed))
        else $error("write began without a valid unlock");
    AST_WRITE_HOLDS: assert property (s_start |=> s_hold)
        else $error("write cut short");
    AST_WRITE_TIMED: assert property (s_start |-> ##[395:410] $fell(o_busy))
        else $error("write length off");
    AST_DONE_AT_END: assert property ($fell(o_busy) |-> ##[0:2] o_write_done_flag)
        else $error("done flag missing");
    AST_DONE_STICKY: assert property (o_write_done_flag && !i_done_clr |=> o_write_done_flag)
        else $error("done flag dropped");
    AST_DONE_CLEAR: assert property (i_done_clr && !o_busy |=> !o_write_done_flag)
        else $error("done flag not cleared");
    AST_PROG_DENIED: assert property (i_prog_rd && i_code_protect |=> o_prog_denied && o_prog_rdata == 8'h00)
        else $error("programmer not refused");
    AST_UNLOCK_ZERO: assert property (i_bus.addr == nvc_pkg::ADDR_UNLOCK |=> o_rdata == 8'h00)
        else $error("unlock port not zero");
    AST_CTRL_UPPER: assert property (i_bus.addr == nvc_pkg::ADDR_CTRL |=> o_rdata[7:4] == 4'h0)
        else $error("control upper bits set");
    AST_ADDR_TOP: assert property (i_bus.addr == nvc_pkg::ADDR_ADDRESS |=> !o_rdata[7])
        else $error("address top bit set");
endmodule
bind nvc_ctrl nvc_ctrl_checker #(.PWRT_CYCLES(PWRT_CYCLES)) u_chk (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_bus(i_bus), .i_code_protect(i_code_protect), .i_prog_rd(i_prog_rd), .i_done_clr(i_done_clr),
    .o_rdata(o_rdata), .o_write_done_flag(o_write_done_flag), .o_busy(o_busy),
    .o_prog_rdata(o_prog_rdata), .o_prog_denied(o_prog_denied));
`default_nettype wire

// *** sim/tb.sv ***
// testbench: eeprom controller through its special registers
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    logic clk = 0, rst = 1, por = 0, abr = 0, cp = 0, prd = 0, dclr = 0, rv, done, busy, pden;
    logic [6:0] paddr = '0, a;
    logic [7:0] rdata, prdata, d;
    logic [7:0] mem [128];
    logic [15:0] q [$];
    logic [15:0] note;
    nvc_pkg::nvc_bus_t bus;
    int errors = 0, comparisons = 0, seed = 32'h3ed8676c;
    always #5 clk = ~clk;
    nvc_core_model core (.i_mclk(clk), .o_bus(bus), .o_rv(rv));
    nvc_ctrl #(.PWRT_CYCLES(20)) DUT (.i_mclk(clk), .i_rst(rst), .i_por(por), .i_abort_rst(abr),
        .i_bus(bus), .i_code_protect(cp), .i_prog_rd(prd), .i_prog_addr(paddr), .i_done_clr(dclr),
        .o_rdata(rdata), .o_write_done_flag(done), .o_busy(busy), .o_prog_rdata(prdata),
        .o_prog_denied(pden));
    task automatic chk_rd(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] e);
        q.push_back({m, e});
        core.rd(ad);
    endtask
    always @(negedge clk) if (rv === 1'b1 && q.size() > 0) begin
        note = q.pop_front();
        `CHK(rdata & note[15:8], note[7:0])
    end
    task automatic wait_busy(input logic v);
        int n;
        for (n = 0; n < 600 && busy !== v; n++) @(negedge clk);
        if (busy !== v) errors++;
    endtask
    task automatic start_write(input logic [6:0] ad, input logic [7:0] dd);
        core.wr(nvc_pkg::ADDR_ADDRESS, {1'b0, ad});
        core.wr(nvc_pkg::ADDR_DATA, dd);
        core.wr(nvc_pkg::ADDR_CTRL, 8'h04);
        core.unlock(0, 8'h06);
        wait_busy(1'b1);
    endtask
    task automatic refused(input int gap, input logic [7:0] c);
        core.unlock(gap, c);
        repeat (3) @(negedge clk);
        `CHK(busy, 1'b0)
    endtask
    task automatic conclude;
        if (errors == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk) {rst, por} = 2'b01;
        @(negedge clk) por = 1'b0;
        refused(0, 8'h06);
        chk_rd(nvc_pkg::ADDR_CTRL, 8'hff, 8'h04);
        chk_rd(nvc_pkg::ADDR_UNLOCK, 8'hff, 8'h00);
        core.wr(nvc_pkg::ADDR_ADDRESS, 8'hff);
        chk_rd(nvc_pkg::ADDR_ADDRESS, 8'hff, 8'h7f);
        repeat (25) @(negedge clk);
        core.wr(nvc_pkg::ADDR_CTRL, 8'h00);
        refused(0, 8'h02);
        core.wr(nvc_pkg::ADDR_CTRL, 8'h04);
        refused(1, 8'h06);
        start_write(7'h33, 8'hc3);
        @(negedge clk) abr = 1'b1;
        @(negedge clk) {abr, rst} = 2'b01;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk_rd(nvc_pkg::ADDR_CTRL, 8'h0a, 8'h08);
        chk_rd(nvc_pkg::ADDR_ADDRESS, 8'hff, 8'h33);
        chk_rd(nvc_pkg::ADDR_DATA, 8'hff, 8'hc3);
        repeat (25) @(negedge clk);
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : 7'($random(seed));
            d = 8'($random(seed));
            start_write(a, d);
            mem[a] = d;
            if (i[0]) core.wr(nvc_pkg::ADDR_CTRL, 8'h00);
            core.wr(nvc_pkg::ADDR_ADDRESS, {1'b0, ~a});
            wait_busy(1'b0);
            repeat (3) @(negedge clk);
            `CHK(done, 1'b1)
            @(negedge clk) dclr = 1'b1;
            @(negedge clk) dclr = 1'b0;
            `CHK(done, 1'b0)
            chk_rd(nvc_pkg::ADDR_CTRL, 8'h0f, {5'h0, ~i[0], 2'b00});
            chk_rd(nvc_pkg::ADDR_ADDRESS, 8'hff, {1'b0, a});
            core.wr(nvc_pkg::ADDR_CTRL, 8'h01);
            chk_rd(nvc_pkg::ADDR_DATA, 8'hff, d);
            core.wr(nvc_pkg::ADDR_ADDRESS, 8'h00);
            chk_rd(nvc_pkg::ADDR_DATA, 8'hff, d);
        end
        paddr = a;
        for (int p = 1; p >= 0; p--) begin
            @(negedge clk) {cp, prd} = {p[0], 1'b1};
            @(negedge clk) prd = 1'b0;
            `CHK(pden, p[0])
            `CHK(prdata, p[0] ? 8'h00 : mem[a])
        end
        repeat (2) @(negedge clk);
        conclude();
    end
endmodule
`default_nettype wire
